// ==== verilog/tws_pkg.sv ====
// Behaviour
// [RQ1] run only when spi off or relocated
// [RQ2] mode bit 3: master software, else slave
// [RQ3] master: bit 7 drives data when enabled
// [RQ4] master: bit 6 enables data pin output
// [RQ5] master: bit 5 drives serial clock pin
// [RQ6] master: bit 4 captures data when undriven
// [RQ7] slave: bit 7 enables stop event
// [RQ8] slave: bit 6 sticky general call seen
// [RQ9] slave: bits 5:4 report event cause
// [RQ10] slave: bit 2 holds interface in reset
// [RQ11] slave: bit 1 shows transmit direction
// [RQ12] slave: bit 0 set per byte done
// [RQ13] data register read clears bit 0
// [RQ14] address registers hold 7-bit addresses
// [RQ15] address reset values 55h, 00h, 00h
// [RQ16] master input sampled on clock rise
// [RQ17] slave stretches clock until flag cleared
// [RQ18] data register write also clears flag
// [RQ19] byte with not-acknowledge sets no flag
// [RQ20] master: bits 2:0 read zero
package tws_pkg;
	typedef logic [7:0] tws_byte_t;

	// register offsets on the core register port
	localparam tws_byte_t TWS_OFF_ADDR2ND = 8'h91;
	localparam tws_byte_t TWS_OFF_ADDR3RD = 8'h92;
	localparam tws_byte_t TWS_OFF_BUF     = 8'h9a;
	localparam tws_byte_t TWS_OFF_ADDR1ST = 8'h9b;
	localparam tws_byte_t TWS_OFF_CTRL    = 8'he8;

	// reset values
	localparam tws_byte_t TWS_RST_ADDR1ST = 8'h55;
	localparam tws_byte_t TWS_RST_ADDROTH = 8'h00;
	localparam tws_byte_t TWS_RST_BYTE    = 8'h00;

	// control register field positions
	localparam int TWS_B_TOP  = 7;
	localparam int TWS_B_SIX  = 6;
	localparam int TWS_B_MCLK = 5;
	localparam int TWS_B_MSEL = 3;
	localparam int TWS_B_SRST = 2;

	// event cause codes
	localparam logic [1:0] TWS_C_START  = 2'h0;
	localparam logic [1:0] TWS_C_RSTART = 2'h1;
	localparam logic [1:0] TWS_C_DATA   = 2'h2;
	localparam logic [1:0] TWS_C_STOP   = 2'h3;

	localparam logic [6:0] TWS_GCALL = 7'h00;
	localparam logic [3:0] TWS_NBITS = 4'h8;

	typedef enum logic [2:0] {
		TWS_IDLE = 3'h0,
		TWS_RECV = 3'h1,
		TWS_ACK  = 3'h3,
		TWS_HOLD = 3'h2,
		TWS_SEND = 3'h6,
		TWS_MACK = 3'h7
	} tws_state_t;

	// event word handed from link domain to core domain
	typedef struct packed {
		logic [1:0] cause;
		logic       dir;
		logic       gc;
		tws_byte_t  data;
	} tws_evt_t;

	// software-owned control bits
	typedef struct packed {
		logic top;  // master data out / stop event enable
		logic dout_en; // master data out enable
		logic clk_out; // master clock out
		logic msel; // master select
		logic srst; // interface soft reset
	} tws_ctrl_t;
endpackage : tws_pkg

// ==== verilog/tws_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module tws_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk, // destination clock
	input  wire logic         i_rst, // async reset, active high
	input  wire logic [W-1:0] i_d,   // signals from another domain
	output var  logic [W-1:0] o_q    // synchronised copy
);
	logic [W-1:0] meta_reg;

	// two flops; only the second stage is visible outside
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_reg <= '0;
			o_q <= '0;
		end else begin
			meta_reg <= i_d;
			o_q <= meta_reg;
		end
	end
endmodule : tws_sync
`default_nettype wire

// ==== verilog/tws_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tws_top (
	input  wire logic              I_CLK,       // core clock
	input  wire logic              I_RST,       // async reset, active high
	input  wire logic              I_LINK_CLK,  // link sampling clock
	input  wire tws_pkg::tws_byte_t I_SFR_ADDR,  // register address
	input  wire logic              I_SFR_WR,    // write strobe
	input  wire logic              I_SFR_RD,    // read strobe
	input  wire tws_pkg::tws_byte_t I_SFR_WDATA, // write data
	output var  tws_pkg::tws_byte_t O_SFR_RDATA, // read data, next cycle
	input  wire logic              I_SPI_EN,    // spi unit enabled
	input  wire logic              I_SPI_ALT,   // spi moved to other pins
	input  wire logic              I_SCL_IN,    // clock pin level
	output logic                   O_SCL_OUT,   // clock pin drive value
	output logic                   O_SCL_OE,    // clock pin drive enable
	input  wire logic              I_SDA_IN,    // data pin level
	output logic                   O_SDA_OUT,   // data pin drive value
	output logic                   O_SDA_OE,    // data pin drive enable
	output logic                   O_IRQ        // byte done flag level
);
	import tws_pkg::*;

	////////////////////////////////////////////////////////////////
	// core domain state
	tws_ctrl_t  ctrl_reg;
	logic       flag_reg, gc_reg, dir_reg, din_reg;
	logic [1:0] cause_reg;
	tws_byte_t  rx_reg, tx_reg, a1_reg, a2_reg, a3_reg;
	logic       rel_tgl_reg, cfg_tgl_reg, off_reg;
	logic       c_scl, c_sda, c_ev, c_scl_p_reg, c_ev_p_reg;
	logic       active, wr_ctrl, buf_acc, ev_new, gc_clr;

	// link domain state
	tws_state_t state_reg;
	tws_evt_t   ev_reg;
	tws_byte_t  sh_reg, tx_l_reg, la1_reg, la2_reg, la3_reg;
	logic [3:0] cnt_reg;
	logic       ev_tgl_reg, sda_low_reg, scl_low_reg, busy_reg;
	logic       is_addr_reg, rep_reg, ldir_reg, lgc_reg, got_ack_reg;
	logic       l_scl, l_sda, l_rel, l_off, l_cfg, l_si;
	logic       l_scl_p_reg, l_sda_p_reg, l_rel_p_reg, l_cfg_p_reg;
	logic       rise, fall, start_c, stop_c, addr_hit;
	logic       ev_fire;
	logic [1:0] ev_cause;

	////////////////////////////////////////////////////////////////
	// crossings
	tws_sync #(.W(3)) u_core_sync (
		.i_clk (I_CLK),
		.i_rst (I_RST),
		.i_d   ({I_SCL_IN, I_SDA_IN, ev_tgl_reg}),
		.o_q   ({c_scl, c_sda, c_ev})
	);

	tws_sync #(.W(6)) u_link_sync (
		.i_clk (I_LINK_CLK),
		.i_rst (I_RST),
		.i_d   ({I_SCL_IN, I_SDA_IN, rel_tgl_reg, off_reg, cfg_tgl_reg, ctrl_reg.top}),
		.o_q   ({l_scl, l_sda, l_rel, l_off, l_cfg, l_si})
	);

	////////////////////////////////////////////////////////////////
	// core: decode and strobes
	assign active  = ~I_SPI_EN | I_SPI_ALT; // see [RQ1]
	assign wr_ctrl = I_SFR_WR && (I_SFR_ADDR == TWS_OFF_CTRL);
	assign buf_acc = (I_SFR_WR || I_SFR_RD) && (I_SFR_ADDR == TWS_OFF_BUF);
	assign ev_new  = c_ev ^ c_ev_p_reg;
	assign gc_clr  = wr_ctrl && !ctrl_reg.msel && !I_SFR_WDATA[TWS_B_SIX];

	// edge history of synchronised core inputs
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			c_scl_p_reg <= 1'b0;
			c_ev_p_reg <= 1'b0;
		end else begin
			c_scl_p_reg <= c_scl;
			c_ev_p_reg <= c_ev;
		end
	end

	// software control bits; master writes ignore bits 2:0
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			ctrl_reg <= '0;
		end else if (wr_ctrl) begin
			ctrl_reg.top <= I_SFR_WDATA[TWS_B_TOP];
			ctrl_reg.msel <= I_SFR_WDATA[TWS_B_MSEL]; // see [RQ2]
			if (ctrl_reg.msel) begin
				ctrl_reg.dout_en <= I_SFR_WDATA[TWS_B_SIX];
				ctrl_reg.clk_out <= I_SFR_WDATA[TWS_B_MCLK];
			end else begin
				ctrl_reg.srst <= I_SFR_WDATA[TWS_B_SRST]; // see [RQ10]
			end
		end
	end

	// engine held off in master mode, soft reset or pin conflict
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			off_reg <= 1'b1;
		end else begin
			off_reg <= ctrl_reg.msel | ctrl_reg.srst | ~active; // see [RQ10]
		end
	end

	// master data input: sampled on clock rise, only when not driving
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			din_reg <= 1'b0;
		end else if (ctrl_reg.msel && !ctrl_reg.dout_en && c_scl && !c_scl_p_reg) begin
			din_reg <= c_sda; // see [RQ6] see [RQ16]
		end
	end

	// event capture; a new event beats a same-cycle clear
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			flag_reg <= 1'b0;
			cause_reg <= TWS_C_START;
			dir_reg <= 1'b0;
			rx_reg <= TWS_RST_BYTE;
		end else if (ev_new) begin
			flag_reg <= 1'b1; // see [RQ12]
			cause_reg <= ev_reg.cause; // see [RQ9]
			dir_reg <= ev_reg.dir; // see [RQ11]
			rx_reg <= ev_reg.data;
		end else if (buf_acc) begin
			flag_reg <= 1'b0; // see [RQ13] see [RQ18]
		end
	end

	// general call status: set by hardware, cleared by writing zero
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			gc_reg <= 1'b0;
		end else begin
			gc_reg <= (ev_new & ev_reg.gc) | (gc_reg & ~gc_clr); // see [RQ8]
		end
	end

	// release the stretched clock: only the first access per event counts
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			rel_tgl_reg <= 1'b0;
		end else if (buf_acc && flag_reg && !ev_new) begin
			rel_tgl_reg <= ~rel_tgl_reg; // see [RQ17]
		end
	end

	// transmit byte and address registers
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			tx_reg <= TWS_RST_BYTE;
			a1_reg <= TWS_RST_ADDR1ST; // see [RQ15]
			a2_reg <= TWS_RST_ADDROTH;
			a3_reg <= TWS_RST_ADDROTH;
			cfg_tgl_reg <= 1'b0;
		end else if (I_SFR_WR) begin
			if (I_SFR_ADDR == TWS_OFF_BUF) begin
				tx_reg <= I_SFR_WDATA;
			end else if (I_SFR_ADDR == TWS_OFF_ADDR1ST) begin
				a1_reg <= I_SFR_WDATA;
				cfg_tgl_reg <= ~cfg_tgl_reg;
			end else if (I_SFR_ADDR == TWS_OFF_ADDR2ND) begin
				a2_reg <= I_SFR_WDATA;
				cfg_tgl_reg <= ~cfg_tgl_reg;
			end else if (I_SFR_ADDR == TWS_OFF_ADDR3RD) begin
				a3_reg <= I_SFR_WDATA;
				cfg_tgl_reg <= ~cfg_tgl_reg;
			end
		end
	end

	// read port; the control view depends on the mode
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_SFR_RDATA <= TWS_RST_BYTE;
		end else if (I_SFR_RD) begin
			if (I_SFR_ADDR == TWS_OFF_CTRL && ctrl_reg.msel) begin
				O_SFR_RDATA <= {ctrl_reg.top, ctrl_reg.dout_en, ctrl_reg.clk_out, din_reg, 1'b1, 3'h0}; // see [RQ20]
			end else if (I_SFR_ADDR == TWS_OFF_CTRL) begin
				O_SFR_RDATA <= {ctrl_reg.top, gc_reg, cause_reg, 1'b0, ctrl_reg.srst, dir_reg, flag_reg};
			end else if (I_SFR_ADDR == TWS_OFF_BUF) begin
				O_SFR_RDATA <= rx_reg;
			end else if (I_SFR_ADDR == TWS_OFF_ADDR1ST) begin
				O_SFR_RDATA <= a1_reg;
			end else if (I_SFR_ADDR == TWS_OFF_ADDR2ND) begin
				O_SFR_RDATA <= a2_reg;
			end else if (I_SFR_ADDR == TWS_OFF_ADDR3RD) begin
				O_SFR_RDATA <= a3_reg;
			end else begin
				O_SFR_RDATA <= TWS_RST_BYTE;
			end
		end
	end

	// pins: master drives push-pull, slave only pulls low
	assign O_SCL_OE  = active & (ctrl_reg.msel | scl_low_reg); // see [RQ1] see [RQ5]
	assign O_SCL_OUT = ctrl_reg.msel & ctrl_reg.clk_out; // see [RQ5]
	assign O_SDA_OE  = active & (ctrl_reg.msel ? ctrl_reg.dout_en : sda_low_reg); // see [RQ4]
	assign O_SDA_OUT = ctrl_reg.msel & ctrl_reg.top; // see [RQ3]
	assign O_IRQ     = flag_reg;

	////////////////////////////////////////////////////////////////
	// link domain: bus conditions
	assign rise    = l_scl & ~l_scl_p_reg;
	assign fall    = ~l_scl & l_scl_p_reg;
	assign start_c = l_scl & l_scl_p_reg & l_sda_p_reg & ~l_sda;
	assign stop_c  = l_scl & l_scl_p_reg & ~l_sda_p_reg & l_sda;
	assign addr_hit = (sh_reg[7:1] == la1_reg[6:0]) || (sh_reg[7:1] == la2_reg[6:0])
		|| (sh_reg[7:1] == la3_reg[6:0]) || (sh_reg[7:1] == TWS_GCALL); // see [RQ14]

	// history flops; address copies follow each address write
	always_ff @(posedge I_LINK_CLK or posedge I_RST) begin
		if (I_RST) begin
			l_scl_p_reg <= 1'b1;
			l_sda_p_reg <= 1'b1;
			l_rel_p_reg <= 1'b0;
			l_cfg_p_reg <= 1'b0;
			la1_reg <= TWS_RST_ADDR1ST;
			la2_reg <= TWS_RST_ADDROTH;
			la3_reg <= TWS_RST_ADDROTH;
		end else begin
			l_scl_p_reg <= l_scl;
			l_sda_p_reg <= l_sda;
			l_rel_p_reg <= l_rel;
			l_cfg_p_reg <= l_cfg;
			if (l_cfg ^ l_cfg_p_reg) begin
				la1_reg <= a1_reg;
				la2_reg <= a2_reg;
				la3_reg <= a3_reg;
			end
		end
	end

	// event selection; a byte that got a not-acknowledge never fires
	always_comb begin
		ev_fire = 1'b0;
		ev_cause = TWS_C_DATA;
		if (!l_off && stop_c) begin
			ev_fire = busy_reg & l_si; // see [RQ7]
			ev_cause = TWS_C_STOP;
		end else if (!l_off && !start_c && fall && state_reg == TWS_ACK) begin
			ev_fire = 1'b1;
			ev_cause = is_addr_reg ? (rep_reg ? TWS_C_RSTART : TWS_C_START) : TWS_C_DATA; // see [RQ9]
		end else if (!l_off && !start_c && fall && state_reg == TWS_MACK) begin
			ev_fire = got_ack_reg; // see [RQ19]
		end
	end

	// event word: written in the same cycle as the toggle that marks it
	always_ff @(posedge I_LINK_CLK or posedge I_RST) begin
		if (I_RST) begin
			ev_reg <= '0;
			ev_tgl_reg <= 1'b0;
		end else if (ev_fire) begin
			ev_reg.cause <= ev_cause;
			ev_reg.dir <= ldir_reg;
			ev_reg.gc <= lgc_reg;
			ev_reg.data <= (state_reg == TWS_MACK) ? tx_l_reg : sh_reg;
			ev_tgl_reg <= ~ev_tgl_reg;
		end
	end

	// slave protocol engine
	always_ff @(posedge I_LINK_CLK or posedge I_RST) begin
		if (I_RST) begin
			state_reg <= TWS_IDLE;
			cnt_reg <= 4'h0;
			sh_reg <= TWS_RST_BYTE;
			tx_l_reg <= TWS_RST_BYTE;
			sda_low_reg <= 1'b0;
			scl_low_reg <= 1'b0;
			busy_reg <= 1'b0;
			is_addr_reg <= 1'b0;
			rep_reg <= 1'b0;
			ldir_reg <= 1'b0;
			lgc_reg <= 1'b0;
			got_ack_reg <= 1'b0;
		end else if (l_off || stop_c) begin
			state_reg <= TWS_IDLE; // see [RQ10]
			sda_low_reg <= 1'b0;
			scl_low_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else if (start_c) begin
			state_reg <= TWS_RECV;
			cnt_reg <= 4'h0;
			is_addr_reg <= 1'b1;
			rep_reg <= busy_reg;
			sda_low_reg <= 1'b0;
		end else begin
			case (state_reg)
				TWS_RECV: begin
					if (rise) begin
						sh_reg <= {sh_reg[6:0], l_sda};
						cnt_reg <= cnt_reg + 4'h1;
					end else if (fall && cnt_reg == TWS_NBITS) begin
						if (!is_addr_reg || addr_hit) begin
							sda_low_reg <= 1'b1;
							state_reg <= TWS_ACK;
						end else begin
							state_reg <= TWS_IDLE;
							busy_reg <= 1'b0;
						end
						if (is_addr_reg && addr_hit) begin
							busy_reg <= 1'b1;
							ldir_reg <= sh_reg[0]; // see [RQ11]
							lgc_reg <= (sh_reg[7:1] == TWS_GCALL); // see [RQ8]
						end
					end
				end
				TWS_ACK: begin
					if (fall) begin
						sda_low_reg <= 1'b0;
						scl_low_reg <= 1'b1; // see [RQ17]
						state_reg <= TWS_HOLD;
					end
				end
				TWS_HOLD: begin
					if (l_rel ^ l_rel_p_reg) begin
						scl_low_reg <= 1'b0;
						is_addr_reg <= 1'b0;
						if (ldir_reg) begin
							tx_l_reg <= tx_reg;
							sda_low_reg <= ~tx_reg[7];
							sh_reg <= {tx_reg[6:0], 1'b1};
							cnt_reg <= 4'h1;
							state_reg <= TWS_SEND;
						end else begin
							cnt_reg <= 4'h0;
							state_reg <= TWS_RECV;
						end
					end
				end
				TWS_SEND: begin
					if (fall && cnt_reg == TWS_NBITS) begin
						sda_low_reg <= 1'b0;
						got_ack_reg <= 1'b0;
						state_reg <= TWS_MACK;
					end else if (fall) begin
						sda_low_reg <= ~sh_reg[7];
						sh_reg <= {sh_reg[6:0], 1'b1};
						cnt_reg <= cnt_reg + 4'h1;
					end
				end
				TWS_MACK: begin
					if (rise) begin
						got_ack_reg <= ~l_sda;
					end else if (fall && got_ack_reg) begin
						scl_low_reg <= 1'b1;
						state_reg <= TWS_HOLD;
					end else if (fall) begin
						state_reg <= TWS_IDLE; // see [RQ19]
						busy_reg <= 1'b0;
					end
				end
				default: begin
					state_reg <= TWS_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	sequence s_scl_rise;
		c_scl && !c_scl_p_reg;
	endsequence

	sequence s_first_access;
		buf_acc && flag_reg && !ev_new;
	endsequence

	AST_DOUT_DRIVE: assert property (@(posedge I_CLK) disable iff (I_RST) // see [RQ3]
		active && ctrl_reg.msel && ctrl_reg.dout_en |-> O_SDA_OE && (O_SDA_OUT == ctrl_reg.top))
		else $error("master data not driven from bit 7");
	AST_DOUT_RELEASE: assert property (@(posedge I_CLK) disable iff (I_RST) // see [RQ4]
		ctrl_reg.msel && !ctrl_reg.dout_en |-> !O_SDA_OE)
		else $error("data pin driven while output enable clear");
	AST_MCLK_PIN: assert property (@(posedge I_CLK) disable iff (I_RST) // see [RQ5]
		$rose(ctrl_reg.clk_out) && ctrl_reg.msel && active |-> O_SCL_OE && O_SCL_OUT)
		else $error("clock pin does not follow bit 5");
	AST_DIN_SAMPLE: assert property (@(posedge I_CLK) disable iff (I_RST) // see [RQ16]
		s_scl_rise ##0 (ctrl_reg.msel && !ctrl_reg.dout_en) |=> din_reg == $past(c_sda))
		else $error("data input not sampled on clock rise");
	AST_DIN_FROZEN: assert property (@(posedge I_CLK) disable iff (I_RST) // see [RQ6]
		ctrl_reg.dout_en |=> $stable(din_reg))
		else $error("data input changed while driving");
	AST_FLAG_SET: assert property (@(posedge I_CLK) disable iff (I_RST) // see [RQ12]
		ev_new |=> flag_reg && cause_reg == $past(ev_reg.cause))
		else $error("event did not raise flag with its cause");
	AST_FLAG_CLEAR: assert property (@(posedge I_CLK) disable iff (I_RST) // see [RQ13]
		s_first_access |=> !flag_reg && (rel_tgl_reg != $past(rel_tgl_reg)))
		else $error("data access did not clear flag and release");
	AST_RSVD_ZERO: assert property (@(posedge I_CLK) disable iff (I_RST) // see [RQ20]
		I_SFR_RD && I_SFR_ADDR == TWS_OFF_CTRL && ctrl_reg.msel |=> O_SFR_RDATA[2:0] == 3'h0)
		else $error("reserved bits not zero in master mode");
	AST_SPI_OWNS: assert property (@(posedge I_CLK) disable iff (I_RST) // see [RQ1]
		!active |-> !O_SDA_OE && !O_SCL_OE)
		else $error("pins driven while spi owns them");
	AST_STRETCH: assert property (@(posedge I_LINK_CLK) disable iff (I_RST) // see [RQ17]
		state_reg == TWS_HOLD && !l_off && !stop_c && !start_c && !(l_rel ^ l_rel_p_reg) |=> scl_low_reg)
		else $error("clock not held while waiting for software");
	AST_SOFT_RESET: assert property (@(posedge I_LINK_CLK) disable iff (I_RST) // see [RQ10]
		l_off |=> state_reg == TWS_IDLE && !sda_low_reg && !scl_low_reg)
		else $error("engine active while held in reset");
	AST_NACK_QUIET: assert property (@(posedge I_LINK_CLK) disable iff (I_RST) // see [RQ19]
		state_reg == TWS_MACK && !got_ack_reg && fall && !l_off && !stop_c && !start_c
		|=> $stable(ev_tgl_reg) && state_reg == TWS_IDLE)
		else $error("not-acknowledged byte raised an event");
endmodule : tws_top
`default_nettype wire

// ==== bench/tws_bfm_master.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// bus master model: open-drain, so it only ever pulls a line low
module tws_bfm_master #(
	parameter int HP = 1000 // half bit time in ns
) (
	input  wire logic i_scl,     // resolved clock line
	input  wire logic i_sda,     // resolved data line
	output var  logic o_scl_low, // pulls clock low
	output var  logic o_sda_low, // pulls data low
	output var  logic o_hung     // slave held clock past the bound
);
	initial begin
		o_scl_low = 1'b0;
		o_sda_low = 1'b0;
		o_hung    = 1'b0;
	end
	////////////////////////////////////////
	// release clock, then wait out any stretch; bounded so a stuck slave cannot hang the run
	task automatic scl_up();
		o_scl_low = 1'b0;
		for (int k = 0; k < 2000 && i_scl !== 1'b1; k++) #50;
		if (i_scl !== 1'b1) o_hung = 1'b1;
		#HP;
	endtask : scl_up
	task automatic scl_dn();
		o_scl_low = 1'b1;
		#HP;
	endtask : scl_dn
	// start and repeated start share one path: data falls while clock is high
	task automatic start();
		o_sda_low = 1'b0;
		#HP;
		scl_up();
		o_sda_low = 1'b1;
		#HP;
		scl_dn();
	endtask : start
	task automatic stop();
		o_sda_low = 1'b1;
		#HP;
		scl_up();
		o_sda_low = 1'b0;
		#HP;
	endtask : stop
	// data changes only while clock is low, msb first
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			o_sda_low = !b[i];
			#HP;
			scl_up();
			scl_dn();
		end
		o_sda_low = 1'b0;
		#HP;
		scl_up();
		ack = i_sda;
		scl_dn();
	endtask : wr_byte
	task automatic rd_byte(input logic nack, output logic [7:0] b);
		o_sda_low = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			scl_up();
			b[i] = i_sda;
			scl_dn();
		end
		o_sda_low = !nack;
		scl_up();
		scl_dn();
		o_sda_low = 1'b0;
	endtask : rd_byte
endmodule : tws_bfm_master
`default_nettype wire

// ==== bench/tb_tws_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_tws_top;
	import tws_pkg::*;
	logic      clk, rst, link_clk, sfr_wr, sfr_rd, spi_en, spi_alt, rd_seen;
	logic      scl_out, scl_oe, sda_out, sda_oe, irq, m_scl_low, m_sda_low, m_hung, tb_sda_low, ack;
	wire logic scl_bus, sda_bus;
	tws_byte_t sfr_addr, sfr_wdata, sfr_rdata, a2, d, rx;
	tws_byte_t exp_q[$], addr_q[$];
	int        bad_count, cmp_count, r;
	// wired-and with pull-ups: a line is low if any party pulls it
	assign scl_bus = !(scl_oe && !scl_out) && !m_scl_low;
	assign sda_bus = !(sda_oe && !sda_out) && !m_sda_low && !tb_sda_low;
	tws_top i_tws_top (.I_CLK(clk), .I_RST(rst), .I_LINK_CLK(link_clk), .I_SFR_ADDR(sfr_addr),
		.I_SFR_WR(sfr_wr), .I_SFR_RD(sfr_rd), .I_SFR_WDATA(sfr_wdata), .O_SFR_RDATA(sfr_rdata),
		.I_SPI_EN(spi_en), .I_SPI_ALT(spi_alt), .I_SCL_IN(scl_bus), .O_SCL_OUT(scl_out),
		.O_SCL_OE(scl_oe), .I_SDA_IN(sda_bus), .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .O_IRQ(irq));
	tws_bfm_master i_tws_bfm_master (.i_scl(scl_bus), .i_sda(sda_bus), .o_scl_low(m_scl_low),
		.o_sda_low(m_sda_low), .o_hung(m_hung));
	////////////////////////////////////////
	// link clock phase offset keeps the two domains unrelated
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #24 link_clk = ~link_clk;
	end
	////////////////////////////////////////
	task automatic chk_byte(input string n, input tws_byte_t e, input tws_byte_t g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk_byte
	task automatic chk_bit(input string n, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %b seen %b", n, e, g);
		end
	endtask : chk_bit
	task automatic summarize();
		repeat (3) @(posedge clk);
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	// read data is settled by the falling edge after the taking edge
	always @(posedge clk) rd_seen <= sfr_rd;
	always @(negedge clk) begin
		if (rd_seen === 1'b1 && exp_q.size() > 0) chk_byte($sformatf("reg %h", addr_q.pop_front()),
			exp_q.pop_front(), sfr_rdata);
	end
	always @(posedge m_hung) begin
		bad_count++;
		$display("Error clock stretch expected release seen held");
		summarize();
	end
	////////////////////////////////////////
	// two idle edges first: address copies to the link side need 3 cycles of spacing
	task automatic wr(input tws_byte_t a, input tws_byte_t v);
		repeat (2) @(posedge clk);
		#1;
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1'b1;
		@(posedge clk);
		#1;
		sfr_wr = 1'b0;
	endtask : wr
	task automatic rd(input tws_byte_t a, input tws_byte_t e);
		@(posedge clk);
		#1;
		sfr_addr = a;
		sfr_rd = 1'b1;
		exp_q.push_back(e);
		addr_q.push_back(a);
		@(posedge clk);
		#1;
		sfr_rd = 1'b0;
	endtask : rd
	task automatic wait_irq();
		for (int k = 0; k < 400 && irq !== 1'b1; k++) @(posedge clk);
		#1;
		if (irq !== 1'b1) begin
			bad_count++;
			$display("Error irq wait expected 1 seen %b", irq);
			summarize();
		end
	endtask : wait_irq
	task automatic irq_low();
		@(posedge clk);
		#1;
		chk_bit("irq", 1'b0, irq);
	endtask : irq_low
	task automatic test_end(input string n);
		$display("test %s done, mismatches so far %0d", n, bad_count);
	endtask : test_end
	////////////////////////////////////////
	initial begin
		rst = 1'b1;
		{sfr_wr, sfr_rd, spi_en, spi_alt, tb_sda_low} = 5'h00;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		bad_count = 0;
		cmp_count = 0;
		r = $urandom(82);
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (6) @(posedge clk);
		rd(8'h91, 8'h00);
		rd(8'h92, 8'h00);
		rd(8'h9b, 8'h55);
		rd(8'he8, 8'h00);
		rd(8'h9c, 8'h00);
		a2 = 8'h10 + 8'($urandom % 64);
		wr(8'h91, a2);
		wr(8'h92, a2 + 8'h01);
		rd(8'h91, a2);
		rd(8'h92, a2 + 8'h01);
		test_end("registers");
		// data line held low so the input bit stays 0 through the pin loop
		tb_sda_low = 1'b1;
		for (int k = 0; k < 8; k++) begin
			d = {3'(k), 5'h0f};
			wr(8'he8, d);
			chk_bit("scl oe", 1'b1, scl_oe);
			chk_bit("scl out", d[5], scl_out);
			chk_bit("sda oe", d[6], sda_oe);
			if (d[6]) chk_bit("sda out", d[7], sda_out);
			rd(8'he8, d & 8'hf8);
		end
		wr(8'he8, 8'h08);
		tb_sda_low = 1'b0;
		wr(8'he8, 8'h28);
		repeat (5) @(posedge clk);
		rd(8'he8, 8'h38);
		wr(8'he8, 8'h48);
		wr(8'he8, 8'h68);
		repeat (5) @(posedge clk);
		rd(8'he8, 8'h78);
		wr(8'he8, 8'h08);
		tb_sda_low = 1'b1;
		wr(8'he8, 8'h28);
		repeat (5) @(posedge clk);
		rd(8'he8, 8'h28);
		spi_en = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk_bit("scl oe spi on", 1'b0, scl_oe);
		spi_alt = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk_bit("scl oe spi moved", 1'b1, scl_oe);
		{spi_en, spi_alt} = 2'b00;
		wr(8'he8, 8'h08);
		tb_sda_low = 1'b0;
		wr(8'he8, 8'h00);
		chk_bit("scl oe slave", 1'b0, scl_oe);
		test_end("master");
		wr(8'he8, 8'h80);
		i_tws_bfm_master.start();
		i_tws_bfm_master.wr_byte(8'haa, ack);
		chk_bit("addr ack", 1'b0, ack);
		wait_irq();
		chk_bit("stretch", 1'b1, scl_oe);
		rd(8'he8, 8'h81);
		rd(8'h9a, 8'haa);
		irq_low();
		repeat (3) @(posedge clk);
		#1;
		chk_bit("release", 1'b0, scl_oe);
		d = 8'($urandom);
		i_tws_bfm_master.wr_byte(d, ack);
		chk_bit("data ack", 1'b0, ack);
		wait_irq();
		rd(8'he8, 8'ha1);
		rd(8'h9a, d);
		i_tws_bfm_master.stop();
		wait_irq();
		rd(8'he8, 8'hb1);
		wr(8'h9a, 8'h00);
		irq_low();
		test_end("slave receive");
		wr(8'he8, 8'h00);
		i_tws_bfm_master.start();
		i_tws_bfm_master.wr_byte({a2[6:0], 1'b0}, ack);
		chk_bit("second addr ack", 1'b0, ack);
		wait_irq();
		rd(8'he8, 8'h01);
		rd(8'h9a, {a2[6:0], 1'b0});
		i_tws_bfm_master.start();
		i_tws_bfm_master.wr_byte({a2[6:0], 1'b1}, ack);
		chk_bit("read addr ack", 1'b0, ack);
		wait_irq();
		rd(8'he8, 8'h13);
		d = 8'($urandom);
		wr(8'h9a, d);
		irq_low();
		i_tws_bfm_master.rd_byte(1'b1, rx);
		chk_byte("tx byte", d, rx);
		repeat (40) @(posedge clk);
		#1;
		chk_bit("irq after nack", 1'b0, irq);
		i_tws_bfm_master.stop();
		repeat (40) @(posedge clk);
		#1;
		chk_bit("irq stop off", 1'b0, irq);
		test_end("slave transmit");
		i_tws_bfm_master.start();
		i_tws_bfm_master.wr_byte(8'h00, ack);
		chk_bit("gcall ack", 1'b0, ack);
		wait_irq();
		rd(8'he8, 8'h41);
		rd(8'h9a, 8'h00);
		i_tws_bfm_master.stop();
		// general call stays set; an addressed stop with events off leaves the flag clear
		rd(8'he8, 8'h40);
		wr(8'he8, 8'h00);
		rd(8'he8, 8'h00);
		wr(8'he8, 8'h04);
		i_tws_bfm_master.start();
		i_tws_bfm_master.wr_byte(8'haa, ack);
		chk_bit("ack in reset", 1'b1, ack);
		i_tws_bfm_master.stop();
		wr(8'he8, 8'h00);
		i_tws_bfm_master.start();
		i_tws_bfm_master.wr_byte(8'hfe, ack);
		chk_bit("foreign addr ack", 1'b1, ack);
		i_tws_bfm_master.stop();
		i_tws_bfm_master.start();
		i_tws_bfm_master.wr_byte(8'haa, ack);
		chk_bit("ack after reset", 1'b0, ack);
		wait_irq();
		rd(8'h9a, 8'haa);
		i_tws_bfm_master.stop();
		test_end("slave addressing");
		summarize();
	end
endmodule : tb_tws_top
`default_nettype wire
